// ---- rtl/program_step_sequencer.sv ----
// Program step sequencer: step memory, loop and chain control, timing and limit checks
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "seq_defs.svh"

module program_step_sequencer import seq_pkg::*; #(
  parameter int SEC_CYCLES = `SEQ_SEC_TIME_NS / `SEQ_CLK_PERIOD_NS,
  parameter logic [14:0] NOM_CURRENT = 15'h03E8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic start_btn_n,
  input wire logic reset_btn_n,
  input wire meas_t meas,
  output logic output_on,
  output logic [11:0] volt_setpoint,
  output logic [12:0] freq_setpoint,
  output fault_t fault_code,
  output logic current_over_limit_fault,
  output logic alarm,
  output logic fail_lamp,
  output logic protect_lamp
);
  localparam logic [25:0] SEC_LAST = 26'(SEC_CYCLES - 1);

  seq_state_t s;
  seq_state_t n;
  step_t st;
  step_t wst;
  program_set_number_t pg;
  logic [5:0] cur_idx;
  logic [5:0] sel_idx;
  logic standby;
  logic bus_wr;
  logic start_evt;
  logic stop_evt;
  logic sec_tick;
  logic unit_tick;
  logic [11:0] unit_secs;
  logic delay_done;
  logic time_up;
  logic [19:0] total;
  logic [19:0] passes_inc;
  logic [13:0] loop_eff;
  logic [6:0] mult;
  fault_t viol;
  logic [31:0] rdata;
  logic [2:0] next_program_set_number;

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  function automatic logic [5:0] step_idx(input logic [2:0] p, input logic [2:0] k);
    step_idx = 6'(p) * 6'h05 + 6'(k);
  endfunction : step_idx

  function automatic limit_t mk_limit(input logic [15:0] w, input logic [14:0] lo,
                                      input logic [14:0] hi);
    mk_limit.en = w[`SEQ_HALF_MSB];
    mk_limit.val = (w[14:0] < lo) ? lo : ((w[14:0] > hi) ? hi : w[14:0]);
  endfunction : mk_limit

  always_comb begin
    n = s;
    cur_idx = step_idx(s.cur_program_set_number, s.cur_step);
    sel_idx = step_idx(s.program_set_number, s.sel_step);
    st = s.mem[cur_idx];
    wst = s.mem[sel_idx];
    pg = s.progs[s.cur_program_set_number];
    next_program_set_number = s.cur_program_set_number + 3'h1;
    standby = (s.run == ST_STANDBY);
    bus_wr = write && !s.waitrequest && (byteenable == 4'hF);
    rdata = 32'h0000_0000;

    // Pins pass three stages; only the second and the third, its delayed copy, feed edge detection
    n.start_sync = {s.start_sync[1:0], start_btn_n};
    n.reset_sync = {s.reset_sync[1:0], reset_btn_n};
    start_evt = !s.start_sync[1] && s.start_sync[2];
    stop_evt = !s.reset_sync[1] && s.reset_sync[2];

    // Internal timebase: one second tick, then one tick per chosen unit
    case (s.unit_sel)
      2'h1: unit_secs = `SEQ_SEC_PER_MIN;
      2'h2: unit_secs = `SEQ_SEC_PER_HOUR;
      default: unit_secs = 12'h001;
    endcase
    sec_tick = (s.cyc_cnt == SEC_LAST);
    unit_tick = sec_tick && (s.sec_cnt == unit_secs - 12'h001);
    n.cyc_cnt = sec_tick ? 26'h000_0000 : s.cyc_cnt + 26'h000_0001;
    if (sec_tick) begin
      n.sec_cnt = unit_tick ? 12'h000 : s.sec_cnt + 12'h001;
    end
    if (unit_tick && s.elapsed != 14'h3FFF) begin
      n.elapsed = s.elapsed + 14'h0001;
    end

    delay_done = (s.elapsed >= st.decision_delay);
    time_up = (st.ttime != 14'h0000) && (s.elapsed >= st.ttime);
    loop_eff = (pg.loop_count == 14'h0000) ? 14'h0001 : pg.loop_count;
    case (s.mult_sel)
      2'h1: mult = 7'h0A;
      2'h2: mult = 7'h64;
      default: mult = 7'h01;
    endcase
    total = 20'(loop_eff) * 20'(mult);
    passes_inc = s.passes + 20'h0_0001;

    // Fixed priority picks the first violation when several occur together
    viol = FLT_NONE;
    if (st.current_upper_limit.en && meas.current > 16'(st.current_upper_limit.val)) begin
      viol = FLT_CUR_HI;
    end else if (st.current_lower_limit.en &&
                 {4'h0, meas.current} < 20'(st.current_lower_limit.val) * 20'h0_000A) begin
      viol = FLT_CUR_LO;
    end else if (st.power_upper_limit.en && meas.power > 16'(st.power_upper_limit.val)) begin
      viol = FLT_PWR_HI;
    end else if (st.power_lower_limit.en && meas.power < 16'(st.power_lower_limit.val)) begin
      viol = FLT_PWR_LO;
    end else if (st.power_factor_upper_limit.en &&
                 meas.pf > 16'(st.power_factor_upper_limit.val)) begin
      viol = FLT_PF_HI;
    end else if (st.power_factor_lower_limit.en &&
                 meas.pf < 16'(st.power_factor_lower_limit.val)) begin
      viol = FLT_PF_LO;
    end

    // Register read view
    case (address[5:2])
      `SEQ_REG_CONTROL: rdata = {24'h0, s.mult_sel, s.unit_sel, 1'b0, s.high_range, 2'h0};
      `SEQ_REG_STATUS: rdata = {s.passes, s.out_on, s.fault, s.cur_step, s.cur_program_set_number, s.run};
      `SEQ_REG_PROGRAM_SET_NUMBER_SEL: rdata = {25'h0, s.sel_step, 1'b0, s.program_set_number};
      `SEQ_REG_PROGRAM_SET_NUMBER_CFG: rdata = {17'h0, s.progs[s.program_set_number].loop_count,
                                  s.progs[s.program_set_number].auto_sequence_mode};
      `SEQ_REG_STEP_VF: rdata = {3'h0, wst.freq, 4'h0, wst.volt};
      `SEQ_REG_STEP_TIME: rdata = {2'h0, wst.decision_delay, 2'h0, wst.ttime};
      `SEQ_REG_STEP_CUR: rdata = {wst.current_lower_limit, wst.current_upper_limit};
      `SEQ_REG_STEP_PWR: rdata = {wst.power_lower_limit, wst.power_upper_limit};
      `SEQ_REG_STEP_PF: rdata = {wst.power_factor_lower_limit, wst.power_factor_upper_limit};
      `SEQ_REG_STEP_CHAIN: rdata = {31'h0, wst.chain};
      `SEQ_REG_MAIN_SET: rdata = {3'h0, s.main_freq, 4'h0, s.main_volt};
      default: rdata = 32'h0000_0000;
    endcase

    // One wait cycle per access; the request is acted on when waitrequest is low
    if ((read || write) && s.waitrequest) begin
      n.waitrequest = 1'b0;
      n.readdata = rdata;
    end else begin
      n.waitrequest = 1'b1;
    end

    if (bus_wr && address[5:2] == `SEQ_REG_CONTROL) begin
      start_evt = start_evt || writedata[`SEQ_CTL_GO];
      stop_evt = stop_evt || writedata[`SEQ_CTL_ABORT];
    end

    // Settings change only in standby so a running step never sees a torn update
    if (bus_wr && standby) begin
      case (address[5:2])
        `SEQ_REG_CONTROL: begin
          n.high_range = writedata[`SEQ_CTL_HIGH_RANGE];
          n.unit_sel = writedata[`SEQ_CTL_UNIT_LSB +: 2];
          n.mult_sel = writedata[`SEQ_CTL_MULT_LSB +: 2];
        end
        `SEQ_REG_PROGRAM_SET_NUMBER_SEL: begin
          n.program_set_number = writedata[2:0];
          n.sel_step = (writedata[6:4] > 3'h4) ? 3'h4 : writedata[6:4];
        end
        `SEQ_REG_PROGRAM_SET_NUMBER_CFG: begin
          n.progs[s.program_set_number].auto_sequence_mode = writedata[0];
          n.progs[s.program_set_number].loop_count =
            14'(clamp16({2'h0, writedata[14:1]}, 16'h0000, `SEQ_COUNT_MAX));
        end
        `SEQ_REG_STEP_VF, `SEQ_REG_MAIN_SET: begin
          wst.volt = 12'(clamp16(writedata[15:0], 16'h0000,
                             s.high_range ? `SEQ_VOLT_MAX : `SEQ_VOLT_LOW_RANGE_MAX));
          wst.freq = 13'(clamp16(writedata[31:16], `SEQ_FREQ_MIN, `SEQ_FREQ_MAX));
          if (address[5:2] == `SEQ_REG_MAIN_SET) begin
            n.main_volt = wst.volt;
            n.main_freq = wst.freq;
          end
        end
        `SEQ_REG_STEP_TIME: begin
          wst.ttime = 14'(clamp16(writedata[15:0], 16'h0000, `SEQ_COUNT_MAX));
          wst.decision_delay = 14'(clamp16(writedata[31:16], 16'h0000, `SEQ_COUNT_MAX));
          if (wst.ttime == 14'h0000) begin
            wst.decision_delay = 14'h0000;
          end else if (wst.decision_delay > wst.ttime) begin
            wst.decision_delay = wst.ttime;
          end
        end
        `SEQ_REG_STEP_CUR: begin
          wst.current_upper_limit = mk_limit(writedata[15:0], 15'h0000, NOM_CURRENT);
          wst.current_lower_limit = mk_limit(writedata[31:16], 15'h0000, 15'h7FFF);
        end
        `SEQ_REG_STEP_PWR: begin
          wst.power_upper_limit = mk_limit(writedata[15:0], 15'h0000, 15'h7FFF);
          wst.power_lower_limit = mk_limit(writedata[31:16], 15'h0000, 15'h7FFF);
        end
        `SEQ_REG_STEP_PF: begin
          wst.power_factor_upper_limit =
            mk_limit(writedata[15:0], 15'(`SEQ_PF_MIN), 15'(`SEQ_PF_MAX));
          wst.power_factor_lower_limit =
            mk_limit(writedata[31:16], 15'(`SEQ_PF_MIN), 15'(`SEQ_PF_MAX));
        end
        `SEQ_REG_STEP_CHAIN: wst.chain = writedata[0];
        default: ;
      endcase
      n.mem[sel_idx] = wst;
    end

    case (s.run)
      ST_STANDBY: begin
        n.out_on = 1'b0;
        n.volt_out = s.main_volt;
        n.freq_out = s.main_freq;
        if (start_evt) begin
          n.run = ST_RUN;
          n.cur_program_set_number = s.program_set_number;
          n.manual = !s.progs[s.program_set_number].auto_sequence_mode;
          n.cur_step = n.manual ? s.sel_step : 3'h0;
          n.passes = 20'h0_0000;
          n.elapsed = 14'h0000;
          n.cyc_cnt = 26'h000_0000;
          n.sec_cnt = 12'h000;
        end
      end
      ST_RUN: begin
        n.out_on = 1'b1;
        n.volt_out = st.volt;
        n.freq_out = st.freq;
        // A step stored under the high range must not reach the output once the range is low
        if (!s.high_range && 16'(st.volt) > `SEQ_VOLT_LOW_RANGE_MAX) begin
          n.volt_out = 12'(`SEQ_VOLT_LOW_RANGE_MAX);
        end
        // Limits are judged only once the output has been driven, so readings are live
        if (stop_evt) begin
          n.run = ST_STANDBY;
          n.out_on = 1'b0;
        end else if (s.out_on && delay_done && viol != FLT_NONE) begin
          n.run = ST_FAULT;
          n.fault = viol;
          n.over_fault = (viol == FLT_CUR_HI);
          n.out_on = 1'b0;
          n.alarm = 1'b1;
          n.fail_lamp = 1'b1;
          n.protect_lamp = 1'b1;
        end else if (time_up) begin
          n.elapsed = 14'h0000;
          n.cyc_cnt = 26'h000_0000;
          n.sec_cnt = 12'h000;
          if (s.manual) begin
            n.run = ST_STANDBY;
            n.out_on = 1'b0;
          end else if (st.chain && s.cur_step != 3'h4) begin
            n.cur_step = s.cur_step + 3'h1;
          end else if (pg.loop_count == `SEQ_LOOP_CONT || passes_inc < total) begin
            n.passes = passes_inc;
            n.cur_step = 3'h0;
          end else if (st.chain && s.cur_step == 3'h4 && s.cur_program_set_number != 3'h7 &&
                       s.progs[next_program_set_number].auto_sequence_mode) begin
            n.cur_program_set_number = next_program_set_number;
            n.cur_step = 3'h0;
            n.passes = 20'h0_0000;
          end else begin
            n.run = ST_STANDBY;
            n.out_on = 1'b0;
          end
        end
      end
      ST_FAULT: begin
        n.out_on = 1'b0;
        if (sec_tick) begin
          n.fail_lamp = !s.fail_lamp;
        end
        // First reset only silences the alarm; the message stays for the operator
        if (stop_evt) begin
          n.run = ST_FAULT_QUIET;
          n.alarm = 1'b0;
        end
      end
      ST_FAULT_QUIET: begin
        n.out_on = 1'b0;
        if (sec_tick) begin
          n.fail_lamp = !s.fail_lamp;
        end
        if (stop_evt) begin
          n.run = ST_STANDBY;
          n.fault = FLT_NONE;
          n.over_fault = 1'b0;
          n.fail_lamp = 1'b0;
          n.protect_lamp = 1'b0;
        end
      end
      default: n.run = ST_STANDBY;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '0;
      s.waitrequest <= 1'b1;
      s.start_sync <= 3'h7;
      s.reset_sync <= 3'h7;
      s.main_freq <= `SEQ_FREQ_RESET;
    end else if (clk_en) begin
      s <= n;
    end
  end

  assign readdata = s.readdata;
  assign waitrequest = s.waitrequest;
  assign output_on = s.out_on;
  assign volt_setpoint = s.volt_out;
  assign freq_setpoint = s.freq_out;
  assign fault_code = s.fault;
  assign current_over_limit_fault = s.over_fault;
  assign alarm = s.alarm;
  assign fail_lamp = s.fail_lamp;
  assign protect_lamp = s.protect_lamp;
endmodule : program_step_sequencer

// ---- rtl/seq_defs.svh ----
// Offsets, field positions, reset values and timing counts of the step sequencer
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

`define SEQ_NUM_PROGS 8
`define SEQ_NUM_STEPS 5
`define SEQ_TOTAL_STEPS 40

`define SEQ_REG_CONTROL 4'h0
`define SEQ_REG_STATUS 4'h1
`define SEQ_REG_PROGRAM_SET_NUMBER_SEL 4'h2
`define SEQ_REG_PROGRAM_SET_NUMBER_CFG 4'h3
`define SEQ_REG_STEP_VF 4'h4
`define SEQ_REG_STEP_TIME 4'h5
`define SEQ_REG_STEP_CUR 4'h6
`define SEQ_REG_STEP_PWR 4'h7
`define SEQ_REG_STEP_PF 4'h8
`define SEQ_REG_STEP_CHAIN 4'h9
`define SEQ_REG_MAIN_SET 4'hA

`define SEQ_CTL_GO 0
`define SEQ_CTL_ABORT 1
`define SEQ_CTL_HIGH_RANGE 2
`define SEQ_CTL_UNIT_LSB 4
`define SEQ_CTL_MULT_LSB 6
`define SEQ_HALF_MSB 15
`define SEQ_UPPER_LSB 16

`define SEQ_VOLT_MAX 16'h0BB8
`define SEQ_VOLT_LOW_RANGE_MAX 16'h05DC
`define SEQ_FREQ_MIN 16'h01C2
`define SEQ_FREQ_MAX 16'h1388
`define SEQ_COUNT_MAX 16'h270F
`define SEQ_PF_MIN 16'h0001
`define SEQ_PF_MAX 16'h03E8
`define SEQ_LOOP_CONT 14'h0001
`define SEQ_FREQ_RESET 13'h01F4

`define SEQ_SEC_TIME_NS 1000000000
`define SEQ_CLK_PERIOD_NS 25
`define SEQ_SEC_PER_MIN 12'h03C
`define SEQ_SEC_PER_HOUR 12'hE10

`endif

// ---- rtl/seq_pkg.sv ----
// Types shared by the program step sequencer
package seq_pkg;
  `include "seq_defs.svh"

  typedef enum logic [1:0] {
    ST_STANDBY = 2'h0,
    ST_RUN = 2'h1,
    ST_FAULT = 2'h3,
    ST_FAULT_QUIET = 2'h2
  } run_state_t;

  typedef enum logic [2:0] {
    FLT_NONE = 3'h0,
    FLT_CUR_HI = 3'h1,
    FLT_CUR_LO = 3'h2,
    FLT_PWR_HI = 3'h3,
    FLT_PWR_LO = 3'h4,
    FLT_PF_HI = 3'h5,
    FLT_PF_LO = 3'h6
  } fault_t;

  typedef struct packed {
    logic en;
    logic [14:0] val;
  } limit_t;

  typedef struct packed {
    logic [11:0] volt;
    logic [12:0] freq;
    logic [13:0] ttime;
    logic [13:0] decision_delay;
    limit_t current_upper_limit;
    limit_t current_lower_limit;
    limit_t power_upper_limit;
    limit_t power_lower_limit;
    limit_t power_factor_upper_limit;
    limit_t power_factor_lower_limit;
    logic chain;
  } step_t;

  typedef struct packed {
    logic auto_sequence_mode;
    logic [13:0] loop_count;
  } program_set_number_t;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] power;
    logic [15:0] pf;
  } meas_t;

  typedef struct packed {
    step_t [`SEQ_TOTAL_STEPS-1:0] mem;
    program_set_number_t [`SEQ_NUM_PROGS-1:0] progs;
    run_state_t run;
    fault_t fault;
    logic [2:0] program_set_number;
    logic [2:0] sel_step;
    logic [2:0] cur_program_set_number;
    logic [2:0] cur_step;
    logic manual;
    logic [1:0] unit_sel;
    logic [1:0] mult_sel;
    logic high_range;
    logic [11:0] main_volt;
    logic [12:0] main_freq;
    logic [25:0] cyc_cnt;
    logic [11:0] sec_cnt;
    logic [13:0] elapsed;
    logic [19:0] passes;
    logic [2:0] start_sync;
    logic [2:0] reset_sync;
    logic waitrequest;
    logic [31:0] readdata;
    logic out_on;
    logic [11:0] volt_out;
    logic [12:0] freq_out;
    logic alarm;
    logic fail_lamp;
    logic protect_lamp;
    logic over_fault;
  } seq_state_t;
endpackage : seq_pkg

// ---- dv/seq_port_checks_assertions.sv ----
// Concurrent checks on the ports of the step sequencer
`timescale 1ns/100ps
module seq_port_checks import seq_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic reset_btn_n,
  input wire logic output_on,
  input wire logic [11:0] volt_setpoint,
  input wire logic [12:0] freq_setpoint,
  input wire fault_t fault_code,
  input wire logic current_over_limit_fault,
  input wire logic alarm,
  input wire logic fail_lamp,
  input wire logic protect_lamp
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_bus_answer_next: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered in the next cycle");
  a_bus_answer_once: assert property (!waitrequest |=> waitrequest)
    else $error("bus answer held longer than one cycle");
  a_volt_in_range: assert property (volt_setpoint <= 12'hBB8)
    else $error("voltage setpoint above 300.0 V");
  a_freq_in_range: assert property (freq_setpoint <= 13'h1388)
    else $error("frequency setpoint above 500.0 Hz");
  a_fault_output_off: assert property (fault_code != FLT_NONE |-> !output_on)
    else $error("output left on during a fault");
  a_alarm_with_lamp: assert property ($rose(alarm) |->
    protect_lamp && fault_code != FLT_NONE)
    else $error("alarm raised without protect lamp and fault code");
  a_fail_lamp_fault: assert property (fail_lamp |-> protect_lamp)
    else $error("fail lamp lit outside a fault");
  a_cur_hi_flag: assert property (current_over_limit_fault == (fault_code == FLT_CUR_HI))
    else $error("over-current flag disagrees with fault code");
  a_fault_from_run: assert property ($rose(fault_code != FLT_NONE) |-> $past(output_on))
    else $error("limit fault raised while output was off");
  a_reset_btn_stops: assert property ($fell(reset_btn_n) && output_on |->
    ##[1:6] !output_on)
    else $error("reset button did not end the output");
endmodule : seq_port_checks

// ---- dv/front_panel_model.sv ----
// Front-panel push buttons as an operator presses them
`timescale 1ns/100ps
module front_panel_model (
  input wire logic core_clk,
  output logic start_btn_n,
  output logic reset_btn_n
);
  initial begin
    start_btn_n = 1'b1;
    reset_btn_n = 1'b1;
  end

  // Held six edges: the panel input needs three enabled edges before a press is seen
  task automatic press(input bit rst);
    @(posedge core_clk);
    if (rst) reset_btn_n <= 1'b0;
    else start_btn_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    start_btn_n <= 1'b1;
    reset_btn_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask : press
endmodule : front_panel_model

// ---- dv/program_step_sequencer_tb.sv ----
// Self-checking bench for the program step sequencer
`timescale 1ns/100ps
module program_step_sequencer_tb import seq_pkg::*; ;
  // Short second keeps loop runs affordable while overhead per pass stays below one second
  localparam int SEC = 80;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0, write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata;
  logic waitrequest, start_btn_n, reset_btn_n, output_on, current_over_limit_fault;
  logic alarm, fail_lamp, protect_lamp;
  logic [11:0] volt_setpoint;
  logic [12:0] freq_setpoint;
  meas_t meas = 48'h004B_004B_012C;
  fault_t fault_code;
  logic [31:0] ctl = 32'h4;
  int fails = 0, samples_checked = 0;

  always #12.5 core_clk = ~core_clk;

  program_step_sequencer #(.SEC_CYCLES(SEC)) dut_u (.core_clk, .reset, .clk_en(1'b1), .address,
    .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .start_btn_n, .reset_btn_n,
    .meas, .output_on, .volt_setpoint, .freq_setpoint, .fault_code, .current_over_limit_fault,
    .alarm, .fail_lamp, .protect_lamp);
  front_panel_model panel_u (.core_clk, .start_btn_n, .reset_btn_n);

  task automatic check(input string what, input logic [31:0] seen, want);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic bail;
    fails++;
    $display("mismatch wait expected done seen timeout");
    wrap_up();
  endtask : bail

  task automatic span(input string what, input int n, lo, slack);
    check(what, 32'(n >= lo && n <= lo + slack), 32'h1);
  endtask : span

  task automatic xfer(input bit wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 100) bail();
  endtask : xfer

  task automatic wr(input logic [3:0] r, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, {r, 2'b00}, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] r, output logic [31:0] q);
    xfer(1'b0, {r, 2'b00}, 32'h0, q);
  endtask : rd

  task automatic program_set_number_step(input logic [2:0] p, s, input logic [31:0] tm, input logic ch);
    wr(4'h2, {25'h0, s, 1'b0, p});
    wr(4'h4, 32'h01F4_03E8);
    wr(4'h5, tm);
    wr(4'h6, 32'h0);
    wr(4'h7, 32'h0);
    wr(4'h8, 32'h0);
    wr(4'h9, {31'h0, ch});
  endtask : program_set_number_step

  task automatic set_program_set_number(input logic [2:0] p, input logic au, input logic [13:0] lp);
    wr(4'h2, {29'h0, p});
    wr(4'h3, {17'h0, lp, au});
  endtask : set_program_set_number

  // Starts by GO and counts cycles until the output drops
  task automatic run_len(output int n);
    int k;
    wr(4'h0, ctl | 32'h1);
    k = 0;
    while (output_on !== 1'b1) begin
      @(posedge core_clk);
      if (++k > 10) bail();
    end
    check("run volt", volt_setpoint, 12'h3E8);
    check("run freq", freq_setpoint, 13'h1F4);
    n = 0;
    while (output_on === 1'b1) begin
      @(posedge core_clk);
      if (++n > 20000) bail();
    end
  endtask : run_len

  task automatic s_reset;
    logic [31:0] q;
    check("waitrequest", waitrequest, 1'b1);
    check("output idle", output_on, 1'b0);
    rd(4'h1, q);
    check("status", q, 32'h0);
  endtask : s_reset

  task automatic s_regs;
    logic [71:0] t [16] = '{72'h22_00000070_00000040, 72'h22_00000000_00000000,
      72'h00_00000000_00000000, 72'h44_00640FA0_01C205DC, 72'h00_00000004_00000004,
      72'h44_17700FFF_13880BB8, 72'h55_00090005_00050005, 72'h55_00070000_00000000,
      72'h88_87D08000_83E88001, 72'h66_0000FFFF_000083E8, 72'h33_00007FFF_00004E1F,
      72'hA4_025803E8_025803E8, 72'h22_00000010_00000010, 72'h44_01C20064_01C20064,
      72'h24_00000000_025803E8, 72'hFF_FFFFFFFF_00000000};
    logic [31:0] q;
    foreach (t[i]) begin
      wr(t[i][71:68], t[i][63:32]);
      rd(t[i][67:64], q);
      check("register", q, t[i][31:0]);
    end
    check("main volt", volt_setpoint, 12'h3E8);
  endtask : s_regs

  task automatic s_units;
    int n;
    logic [1:0] u [3] = '{2'h0, 2'h1, 2'h3};
    int tm [3] = '{3, 1, 2};
    int secs [3] = '{3, 60, 2};
    set_program_set_number(3'h0, 1'b0, 14'h0);
    foreach (u[i]) begin
      program_set_number_step(3'h0, 3'h0, 32'(tm[i]), 1'b0);
      ctl = {24'h0, 2'h0, u[i], 4'h4};
      run_len(n);
      span("step time", n, secs[i] * SEC, 6);
    end
  endtask : s_units

  task automatic s_loops;
    int n;
    logic [13:0] lp [5] = '{14'h0, 14'h2, 14'h2, 14'h2, 14'h2};
    logic [1:0] m [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic au [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    int ps [5] = '{1, 20, 200, 2, 1};
    program_set_number_step(3'h0, 3'h0, 32'h1, 1'b0);
    foreach (lp[i]) begin
      set_program_set_number(3'h0, au[i], lp[i]);
      ctl = {24'h0, m[i], 6'h04};
      run_len(n);
      span("passes", n, ps[i] * SEC, ps[i] * 3 + 6);
    end
    ctl = 32'h4;
  endtask : s_loops

  task automatic s_chain;
    int n;
    for (int s = 0; s < 5; s++) program_set_number_step(3'h0, 3'(s), 32'h1, 1'b1);
    program_set_number_step(3'h1, 3'h0, 32'h1, 1'b0);
    for (int a = 0; a < 2; a++) begin
      set_program_set_number(3'h1, 1'(a), 14'h0);
      set_program_set_number(3'h0, 1'b1, 14'h0);
      run_len(n);
      span("chain", n, (5 + a) * SEC, 24);
    end
  endtask : s_chain

  task automatic s_abort;
    logic [31:0] q;
    program_set_number_step(3'h0, 3'h0, 32'h1, 1'b0);
    set_program_set_number(3'h0, 1'b1, 14'h1);
    panel_u.press(1'b0);
    repeat (4 * SEC) @(posedge core_clk);
    check("continuous", output_on, 1'b1);
    panel_u.press(1'b1);
    check("stopped", output_on, 1'b0);
    rd(4'h1, q);
    check("standby", q[1:0], 2'h0);
  endtask : s_abort

  task automatic s_faults;
    int n;
    logic lamp;
    logic [3:0] fr [7] = '{4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h6};
    logic [31:0] fl [7] = '{32'h0000_8064, 32'h8005_0000, 32'h0000_8064, 32'h8032_0000,
      32'h0000_81F4, 32'h80C8_0000, 32'h0000_0064};
    meas_t fm [7] = '{48'h0096_004B_012C, 48'h0014_004B_012C, 48'h004B_0096_012C,
      48'h004B_0014_012C, 48'h004B_004B_0320, 48'h004B_004B_0064, 48'h0096_004B_012C};
    fault_t fc [7] = '{FLT_CUR_HI, FLT_CUR_LO, FLT_PWR_HI, FLT_PWR_LO, FLT_PF_HI, FLT_PF_LO,
      FLT_NONE};
    set_program_set_number(3'h0, 1'b1, 14'h0);
    foreach (fr[i]) begin
      program_set_number_step(3'h0, 3'h0, i == 0 ? 32'h0002_0005 : 32'h5, 1'b0);
      wr(fr[i], fl[i]);
      meas <= fm[i];
      run_len(n);
      check("fault code", fault_code, fc[i]);
      span("fault time", n, fc[i] == FLT_NONE ? 5 * SEC : i == 0 ? 2 * SEC : 0, 8);
      if (fc[i] != FLT_NONE) begin
        check("lamps", {alarm, protect_lamp, current_over_limit_fault}, {2'h3, i == 0});
        lamp = fail_lamp;
        repeat (SEC) @(posedge core_clk);
        check("lamp flash", fail_lamp, !lamp);
        panel_u.press(1'b1);
        check("alarm silenced", alarm, 1'b0);
        panel_u.press(1'b1);
        check("cleared", {fault_code, protect_lamp, fail_lamp}, 5'h00);
      end
      meas <= 48'h004B_004B_012C;
    end
  endtask : s_faults

  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    s_reset();
    s_regs();
    s_units();
    s_loops();
    s_chain();
    s_abort();
    s_faults();
    wrap_up();
  end
endmodule : program_step_sequencer_tb

bind program_step_sequencer seq_port_checks chk_u (.core_clk, .reset, .read, .write,
  .waitrequest, .reset_btn_n, .output_on, .volt_setpoint, .freq_setpoint, .fault_code,
  .current_over_limit_fault, .alarm, .fail_lamp, .protect_lamp);
